// >>> core/fbpc_top.sv
// Flash block program control: unlock, control and block address registers,
// RAM-to-flash block copy with auto-erase, serial programmer gating and security.
// Assumes the flash macro, CPU core and RAM answer on the same clock.
`timescale 1ns/1ns
module fbpc_top #(
  parameter int POR_CYCLES = fbpc_pkg::FBPC_POR_CYCLES
) (
  // Clock and reset (reset is the external reset pin and power-on)
  input wire logic sys_clk,
  input wire logic rst_n,
  // Special register port
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_word,
  input wire logic [15:0] sfr_wdata,
  output logic [15:0] sfr_rdata,
  // CPU status and reset sources
  input wire logic cpu_in_stop,
  input wire logic cpu_in_reset,
  input wire logic instr_done,
  input wire logic break_instruction,
  input wire logic wdt_overflow,
  input wire logic opcode_trap,
  input wire logic cpu_clock_source,
  output logic soft_reset_req,
  output logic cpu_hold,
  output logic irq_defer,
  // Staging RAM read
  output logic [15:0] ram_addr,
  input wire logic [7:0] ram_rdata,
  // Flash macro
  output logic buf_we,
  output logic [6:0] buf_idx,
  output logic [7:0] buf_data,
  output logic [8:0] block_address_field,
  output logic erase_req,
  output logic write_req,
  input wire logic flash_erase_done,
  input wire logic flash_write_done,
  input wire logic flash_access,
  output logic sense_amp_enable,
  // Serial programmer
  input wire logic ser_start,
  input wire logic ser_is_write,
  input wire logic ser_end,
  input wire logic ser_lock_cmd,
  input wire logic ser_lock_val,
  input wire logic [7:0] ser_rd_raw,
  output logic [7:0] ser_rd_data,
  output logic ser_mode_active,
  output logic ser_protocol_error,
  output logic ser_prog_refused,
  output logic lock_write,
  output logic lock_value,
  input wire logic security_lock
);
  import fbpc_pkg::*;

  typedef struct packed {
    fbpc_state_t st;
    logic saw5;
    logic acc;
    logic program_trigger;
    logic [1:0] fclk;
    logic sense_amp_auto_power;
    logic [FBPC_BLK_W-1:0] blk;
    logic [7:0] idx;
    logic [3:0] div;
    logic [FBPC_POR_W-1:0] por_cnt;
    logic por_done;
    logic ser_active;
    logic ser_err;
    logic ser_ref;
    logic lock_wr;
    logic lock_val;
    logic [7:0] rd_data;
    logic buf_we;
    logic [7:0] buf_data;
    logic erase_req;
    logic write_req;
  } fbpc_regs_t;

  fbpc_regs_t state_reg;
  fbpc_regs_t state_next;
  logic [3:0] div_limit;
  logic tick;
  logic wr_unlock;
  logic wr_ctrl;
  logic wr_block;
  logic soft_rst;

  always_comb begin
    case (state_reg.fclk)
      2'b00: div_limit = FBPC_DIV_16;
      2'b01: div_limit = FBPC_DIV_8;
      2'b10: div_limit = FBPC_DIV_4;
      default: div_limit = FBPC_DIV_2;
    endcase
  end

  assign tick = (state_reg.div == div_limit);
  assign wr_unlock = sfr_wr && !sfr_word && (sfr_addr == FBPC_ADDR_UNLOCK);
  assign wr_ctrl = sfr_wr && !sfr_word && (sfr_addr == FBPC_ADDR_CTRL);
  assign wr_block = sfr_wr && sfr_word && (sfr_addr == FBPC_ADDR_BLOCK);
  assign soft_rst = (break_instruction || wdt_overflow || opcode_trap) && !cpu_in_stop;

  always_comb begin
    state_next = state_reg;
    state_next.ser_err = 1'b0;
    state_next.ser_ref = 1'b0;
    state_next.lock_wr = 1'b0;
    state_next.buf_we = 1'b0;
    state_next.div = (state_reg.st == FBPC_COPY && !tick) ? state_reg.div + 4'h1 : 4'h0;

    // Power-on write protect
    if (!state_reg.por_done) begin
      if (state_reg.por_cnt == FBPC_POR_W'(POR_CYCLES - 1)) begin
        state_next.por_done = 1'b1;
      end else begin
        state_next.por_cnt = state_reg.por_cnt + 1'b1;
      end
    end

    // Unlock sequence
    if (wr_unlock) begin
      if (sfr_wdata[3:0] == FBPC_UNLOCK_FIRST) begin
        state_next.saw5 = 1'b1;
      end else begin
        state_next.saw5 = 1'b0;
        if (state_reg.saw5 && sfr_wdata[3:0] == FBPC_UNLOCK_SECOND) begin
          state_next.acc = 1'b1;
        end
      end
    end else if (sfr_wr) begin
      state_next.saw5 = 1'b0;
    end

    // Control register
    if (wr_ctrl) begin
      state_next.sense_amp_auto_power = sfr_wdata[FBPC_BIT_AMP];
      if (state_reg.acc && !security_lock && state_reg.por_done) begin
        state_next.fclk = {sfr_wdata[FBPC_BIT_FCLK_HI], sfr_wdata[FBPC_BIT_FCLK_LO]};
        if (sfr_wdata[FBPC_BIT_PRG] && state_reg.st == FBPC_IDLE) begin
          state_next.program_trigger = 1'b1;
          state_next.st = FBPC_WAIT_INSTR;
        end
      end
    end
    if (wr_block) begin
      state_next.blk = sfr_wdata[15:FBPC_BLK_LSB];
    end
    if (soft_rst) begin
      state_next.sense_amp_auto_power = 1'b0;
    end

    // Block program sequence
    case (state_reg.st)
      FBPC_IDLE: begin
        state_next.idx = 8'h00;
      end
      FBPC_WAIT_INSTR: begin
        if (instr_done) begin
          state_next.st = FBPC_COPY;
        end
      end
      FBPC_COPY: begin
        if (tick) begin
          state_next.buf_we = 1'b1;
          state_next.buf_data = ram_rdata;
          state_next.idx = state_reg.idx + 8'h01;
          if (state_reg.idx == 8'(FBPC_BLOCK_BYTES - 1)) begin
            state_next.st = FBPC_ERASE;
            state_next.erase_req = 1'b1;
          end
        end
      end
      FBPC_ERASE: begin
        if (flash_erase_done) begin
          state_next.erase_req = 1'b0;
          state_next.write_req = 1'b1;
          state_next.st = FBPC_WRITE;
        end
      end
      FBPC_WRITE: begin
        if (flash_write_done) begin
          state_next.write_req = 1'b0;
          state_next.st = FBPC_FINISH;
        end
      end
      FBPC_FINISH: begin
        state_next.program_trigger = 1'b0;
        state_next.acc = 1'b0;
        state_next.st = FBPC_IDLE;
      end
      default: begin
        state_next.st = FBPC_IDLE;
      end
    endcase

    // Serial programmer gating
    if (ser_start && !state_reg.ser_active) begin
      if (!(cpu_in_reset || cpu_in_stop)) begin
        state_next.ser_err = 1'b1;
      end else begin
        state_next.ser_active = 1'b1;
        if (ser_is_write && (security_lock || !state_reg.por_done)) begin
          state_next.ser_ref = 1'b1;
        end
      end
    end
    if (state_reg.ser_active && ser_end) begin
      state_next.ser_active = 1'b0;
    end
    if (state_reg.ser_active && ser_lock_cmd) begin
      state_next.lock_wr = 1'b1;
      state_next.lock_val = ser_lock_val;
    end
    state_next.rd_data = security_lock ? 8'h00 : ser_rd_raw;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata = 16'hFFFF;
  assign soft_reset_req = soft_rst;
  assign cpu_hold = (state_reg.st != FBPC_IDLE) && (state_reg.st != FBPC_WAIT_INSTR);
  assign irq_defer = cpu_hold;
  assign ram_addr = FBPC_RAM_BASE + {8'h00, state_reg.idx};
  assign buf_we = state_reg.buf_we;
  assign buf_idx = 7'(state_reg.idx - 8'h01);
  assign buf_data = state_reg.buf_data;
  assign block_address_field = state_reg.blk;
  assign erase_req = state_reg.erase_req;
  assign write_req = state_reg.write_req;
  assign sense_amp_enable = ((state_reg.sense_amp_auto_power || cpu_clock_source) ? flash_access : 1'b1)
    || cpu_hold;
  assign ser_rd_data = state_reg.rd_data;
  assign ser_mode_active = state_reg.ser_active;
  assign ser_protocol_error = state_reg.ser_err;
  assign ser_prog_refused = state_reg.ser_ref;
  assign lock_write = state_reg.lock_wr;
  assign lock_value = state_reg.lock_val;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_unlock;
    wr_unlock && sfr_wdata[3:0] == FBPC_UNLOCK_FIRST ##1
      wr_unlock && sfr_wdata[3:0] == FBPC_UNLOCK_SECOND;
  endsequence
  sequence s_trigger;
    wr_ctrl && sfr_wdata[FBPC_BIT_PRG] && state_reg.acc && !security_lock
      && state_reg.por_done && state_reg.st == FBPC_IDLE;
  endsequence

  a_unlock_sets: assert property (s_unlock |=> state_reg.acc)
    else $error("unlock sequence did not set flag");
  a_trigger_waits: assert property (s_trigger |=> !cpu_hold && state_reg.program_trigger)
    else $error("trigger did not wait one instruction");
  a_hold_after_instr: assert property (state_reg.st == FBPC_WAIT_INSTR && instr_done
    |=> cpu_hold)
    else $error("hold not taken after instruction");
  a_finish_clears: assert property (state_reg.st == FBPC_WRITE && flash_write_done
    |=> ##1 !state_reg.program_trigger && !state_reg.acc && !cpu_hold)
    else $error("completion did not clear trigger and flag");
  a_locked_no_prg: assert property (security_lock && state_reg.st == FBPC_IDLE
    |=> state_reg.st == FBPC_IDLE)
    else $error("programming started while locked");
  a_no_acc_no_fclk: assert property (!state_reg.acc |=> $stable(state_reg.fclk))
    else $error("clock select changed without unlock");
  a_amp_write: assert property (wr_ctrl && !soft_rst
    |=> state_reg.sense_amp_auto_power == $past(sfr_wdata[FBPC_BIT_AMP]))
    else $error("auto-power bit write lost");
  a_serial_error: assert property (ser_start && !state_reg.ser_active && !cpu_in_reset
    && !cpu_in_stop |=> ser_protocol_error && !ser_mode_active)
    else $error("serial access outside reset or stop not flagged");
  a_stop_no_reset: assert property (cpu_in_stop |-> !soft_reset_req)
    else $error("reset raised in stop mode");
  a_locked_read_zero: assert property (security_lock |=> ser_rd_data == 8'h00)
    else $error("locked read not blanked");
  a_reads_ones: assert property (sfr_rdata == 16'hFFFF)
    else $error("register read not all ones");

  sequence s_last_byte;
    state_reg.st == FBPC_COPY && tick && state_reg.idx == 8'(FBPC_BLOCK_BYTES - 1);
  endsequence
  sequence s_ser_enter;
    ser_start && !state_reg.ser_active && (cpu_in_reset || cpu_in_stop);
  endsequence

  a_copy_then_erase: assert property (s_last_byte |=> erase_req && !write_req)
    else $error("erase not requested after last byte");
  a_erase_then_write: assert property (state_reg.st == FBPC_ERASE && flash_erase_done
    |=> write_req && !erase_req)
    else $error("write not requested after erase");
  a_copy_in_hold: assert property (buf_we |-> cpu_hold && irq_defer)
    else $error("byte copied without CPU hold");
  a_por_blocks: assert property (!state_reg.por_done && state_reg.st == FBPC_IDLE
    |=> state_reg.st == FBPC_IDLE)
    else $error("programming started during power-on protect");
  a_block_latch: assert property (wr_block
    |=> block_address_field == $past(sfr_wdata[15:FBPC_BLK_LSB]))
    else $error("block address not taken");
  a_lock_cmd: assert property (ser_mode_active && ser_lock_cmd
    |=> lock_write && lock_value == $past(ser_lock_val))
    else $error("lock command not passed on");
  a_no_lock_idle: assert property (!ser_mode_active |=> !lock_write)
    else $error("lock written outside serial mode");
  a_serial_enter: assert property (s_ser_enter |=> ser_mode_active)
    else $error("serial mode not entered");
  a_serial_leave: assert property (ser_mode_active && ser_end |=> !ser_mode_active)
    else $error("serial mode not left");
  a_locked_refuse: assert property (s_ser_enter ##0 (ser_is_write && security_lock)
    |=> ser_prog_refused)
    else $error("locked serial write not refused");
  a_soft_rst_amp: assert property (soft_reset_req |=> !state_reg.sense_amp_auto_power)
    else $error("soft reset left auto-power bit set");
endmodule

// >>> core/fbpc_pkg.sv
// Constants and types for the flash block program control.
// Assumes a single 25 MHz system clock and an 8/16-bit special register port.
package fbpc_pkg;
  // Special register addresses
  localparam logic [15:0] FBPC_ADDR_UNLOCK = 16'h00F0;
  localparam logic [15:0] FBPC_ADDR_CTRL = 16'h00F1;
  localparam logic [15:0] FBPC_ADDR_BLOCK = 16'h00F2;
  // Control register field positions
  localparam int FBPC_BIT_PRG = 0;
  localparam int FBPC_BIT_FCLK_LO = 3;
  localparam int FBPC_BIT_FCLK_HI = 4;
  localparam int FBPC_BIT_AMP = 5;
  localparam logic [7:0] FBPC_CTRL_RESET = 8'hC6;
  // Block address field occupies bits 15..7
  localparam int FBPC_BLK_LSB = 7;
  localparam int FBPC_BLK_W = 9;
  // Unlock nibbles
  localparam logic [3:0] FBPC_UNLOCK_FIRST = 4'h5;
  localparam logic [3:0] FBPC_UNLOCK_SECOND = 4'hA;
  // Staging RAM window and block size
  localparam logic [15:0] FBPC_RAM_BASE = 16'h0300;
  localparam int FBPC_BLOCK_BYTES = 128;
  // Transfer clock divider limits (divide by 16, 8, 4, 2)
  localparam logic [3:0] FBPC_DIV_16 = 4'hF;
  localparam logic [3:0] FBPC_DIV_8 = 4'h7;
  localparam logic [3:0] FBPC_DIV_4 = 4'h3;
  localparam logic [3:0] FBPC_DIV_2 = 4'h1;
  // Power-on write protect time
  localparam longint FBPC_CLK_HZ = 25_000_000;
  localparam longint FBPC_POR_TIME_MS = 20;
  localparam int FBPC_POR_CYCLES = int'(FBPC_CLK_HZ * FBPC_POR_TIME_MS / 1000);
  localparam int FBPC_POR_W = 20;

  typedef enum logic [2:0] {
    FBPC_IDLE,
    FBPC_WAIT_INSTR,
    FBPC_COPY,
    FBPC_ERASE,
    FBPC_WRITE,
    FBPC_FINISH
  } fbpc_state_t;
endpackage

// >>> dv/fbpc_flash_model.sv
// Far-side model: staging RAM contents and the flash macro erase/write handshake.
// Assumes the requests are levels that stay high until the matching done pulse.
`timescale 1ns/1ns
module fbpc_flash_model #(
  parameter int DONE_DELAY = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Staging RAM
  input wire logic [15:0] ram_addr,
  output logic [7:0] ram_rdata,
  // Flash macro
  input wire logic erase_req,
  input wire logic write_req,
  output logic flash_erase_done,
  output logic flash_write_done
);
  int cnt;
  // Byte pattern tied to the address so misplaced copies show
  assign ram_rdata = ram_addr[7:0] ^ 8'h5A;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      flash_erase_done <= 1'b0;
      flash_write_done <= 1'b0;
    end else begin
      flash_erase_done <= 1'b0;
      flash_write_done <= 1'b0;
      if ((erase_req || write_req) && cnt < DONE_DELAY) begin
        cnt <= cnt + 1;
      end else if (erase_req || write_req) begin
        cnt <= 0;
        // Block erase completes before the write is answered
        flash_erase_done <= erase_req;
        flash_write_done <= write_req && !erase_req;
      end
    end
  end
endmodule

// >>> dv/flash_block_program_control_test.sv
// Self-checking bench for the flash block program control.
// Assumes the flash macro model and a 25 MHz clock; power-on protect shortened to 16.
`timescale 1ns/1ns
module flash_block_program_control_test;
  import fbpc_pkg::*;
  logic sys_clk = 0, rst_n = 0, sfr_wr = 0, sfr_word = 0, cpu_in_stop = 0;
  logic cpu_in_reset = 0, instr_done = 0, break_instruction = 0, wdt_overflow = 0;
  logic opcode_trap = 0, cpu_clock_source = 0, flash_access = 0, ser_start = 0;
  logic ser_is_write = 0, ser_end = 0, ser_lock_cmd = 0, ser_lock_val = 0, security_lock = 0;
  logic [15:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, ram_addr;
  logic [7:0] ram_rdata, buf_data, ser_rd_data, first_byte, ser_rd_raw = 0;
  logic [6:0] buf_idx;
  logic [8:0] block_address_field;
  logic soft_reset_req, cpu_hold, irq_defer, buf_we, erase_req, write_req, flash_erase_done;
  logic flash_write_done, sense_amp_enable, ser_mode_active, ser_protocol_error;
  logic ser_prog_refused, lock_write, lock_value;
  int n_mismatch = 0, checks_done = 0, n_buf = 0;

  fbpc_top #(.POR_CYCLES(16)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_word(sfr_word),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cpu_in_stop(cpu_in_stop), .cpu_in_reset(cpu_in_reset), .instr_done(instr_done),
    .break_instruction(break_instruction), .wdt_overflow(wdt_overflow),
    .opcode_trap(opcode_trap), .cpu_clock_source(cpu_clock_source),
    .soft_reset_req(soft_reset_req), .cpu_hold(cpu_hold), .irq_defer(irq_defer),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .buf_we(buf_we), .buf_idx(buf_idx), .buf_data(buf_data),
    .block_address_field(block_address_field), .erase_req(erase_req),
    .write_req(write_req), .flash_erase_done(flash_erase_done),
    .flash_write_done(flash_write_done), .flash_access(flash_access),
    .sense_amp_enable(sense_amp_enable),
    .ser_start(ser_start), .ser_is_write(ser_is_write), .ser_end(ser_end),
    .ser_lock_cmd(ser_lock_cmd), .ser_lock_val(ser_lock_val), .ser_rd_raw(ser_rd_raw),
    .ser_rd_data(ser_rd_data), .ser_mode_active(ser_mode_active),
    .ser_protocol_error(ser_protocol_error), .ser_prog_refused(ser_prog_refused),
    .lock_write(lock_write), .lock_value(lock_value), .security_lock(security_lock)
  );
  fbpc_flash_model model_i (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .erase_req(erase_req), .write_req(write_req),
    .flash_erase_done(flash_erase_done), .flash_write_done(flash_write_done)
  );

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    n_buf <= n_buf + int'(buf_we === 1'b1);
    if (buf_we === 1'b1 && buf_idx === 7'h00) first_byte <= buf_data;
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_word = (a == FBPC_ADDR_BLOCK);
    sfr_wr = 1;
    tick();
    sfr_wr = 0;
    tick();
  endtask
  task automatic unlock_and_go(logic [15:0] ctrl);
    sfr_addr = FBPC_ADDR_UNLOCK;
    sfr_word = 0;
    sfr_wdata = 16'h0035;
    sfr_wr = 1;
    tick();
    sfr_wdata = 16'h00CA;
    tick();
    sfr_wr = 0;
    tick();
    wr(FBPC_ADDR_CTRL, ctrl);
    instr_done = 1;
    tick();
    instr_done = 0;
    tick();
  endtask
  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic t_regs;
    wr(FBPC_ADDR_UNLOCK, 16'h0005);
    wr(FBPC_ADDR_BLOCK, 16'h5555);
    wr(FBPC_ADDR_UNLOCK, 16'h000A);
    chk("rdata", 16'hFFFF, sfr_rdata);
    chk("block", 16'h00AA, 16'(block_address_field));
    chk("amp", 16'h1, 16'(sense_amp_enable));
    wr(FBPC_ADDR_CTRL, 16'h0001);
    instr_done = 1;
    tick();
    instr_done = 0;
    tick(2);
    chk("hold locked out", 16'h0, 16'(cpu_hold));
  endtask
  task automatic t_program;
    int base;
    base = n_buf;
    unlock_and_go(16'h0011);
    chk("hold", 16'h1, 16'(cpu_hold));
    chk("irq", 16'h1, 16'(irq_defer));
    for (int i = 0; i < 4000 && cpu_hold !== 1'b0; i++) tick();
    chk("released", 16'h0, 16'(cpu_hold));
    chk("bytes", 16'h0080, 16'(n_buf - base));
    chk("byte0", 16'h005A, 16'(first_byte));
    wr(FBPC_ADDR_CTRL, 16'h0001);
    instr_done = 1;
    tick();
    instr_done = 0;
    tick(2);
    chk("hold after", 16'h0, 16'(cpu_hold));
  endtask
  task automatic t_misc;
    cpu_in_stop = 1;
    break_instruction = 1;
    tick();
    chk("stop brk", 16'h0, 16'(soft_reset_req));
    cpu_in_stop = 0;
    tick();
    chk("brk", 16'h1, 16'(soft_reset_req));
    break_instruction = 0;
    wr(FBPC_ADDR_CTRL, 16'h0020);
    chk("amp off", 16'h0, 16'(sense_amp_enable));
    flash_access = 1;
    tick();
    chk("amp need", 16'h1, 16'(sense_amp_enable));
    flash_access = 0;
    wdt_overflow = 1;
    tick();
    wdt_overflow = 0;
    chk("amp soft rst", 16'h1, 16'(sense_amp_enable));
    cpu_clock_source = 1;
    tick();
    chk("amp sub", 16'h0, 16'(sense_amp_enable));
    cpu_clock_source = 0;
  endtask
  task automatic t_serial;
    ser_rd_raw = 8'hA5;
    ser_start = 1;
    tick();
    ser_start = 0;
    chk("proto", 16'h1, 16'(ser_protocol_error));
    chk("raw read", 16'h00A5, 16'(ser_rd_data));
    tick();
    cpu_in_reset = 1;
    ser_start = 1;
    tick();
    ser_start = 0;
    chk("active", 16'h1, 16'(ser_mode_active));
    ser_lock_cmd = 1;
    ser_lock_val = 1;
    tick();
    ser_lock_cmd = 0;
    chk("lock", 16'h3, {lock_write, lock_value});
    ser_end = 1;
    tick();
    ser_end = 0;
    tick();
    chk("ended", 16'h0, 16'(ser_mode_active));
    cpu_in_reset = 0;
    cpu_in_stop = 1;
    ser_start = 1;
    tick();
    ser_start = 0;
    chk("stop active", 16'h1, 16'(ser_mode_active));
    ser_end = 1;
    tick();
    ser_end = 0;
    cpu_in_stop = 0;
    cpu_in_reset = 1;
    security_lock = 1;
    ser_rd_raw = 8'hA5;
    ser_is_write = 1;
    ser_start = 1;
    tick();
    ser_start = 0;
    chk("refused", 16'h1, 16'(ser_prog_refused));
    chk("blank", 16'h0, 16'(ser_rd_data));
    ser_end = 1;
    tick();
    ser_end = 0;
    unlock_and_go(16'h0001);
    chk("locked trig", 16'h0, 16'(cpu_hold));
    security_lock = 0;
    cpu_in_reset = 0;
  endtask
  task automatic t_abort;
    unlock_and_go(16'h0021);
    chk("hold pre", 16'h1, 16'(cpu_hold));
    rst_n = 0;
    tick();
    chk("abort", 16'h0, {cpu_hold, erase_req, write_req});
    chk("amp reset", 16'h1, 16'(sense_amp_enable));
  endtask

  initial begin
    #(40 * 20000);
    n_mismatch++;
    close_out();
  end
  initial begin
    tick(2);
    rst_n = 1;
    tick(20);
    t_regs();
    t_program();
    t_misc();
    t_serial();
    t_abort();
    close_out();
  end
endmodule
